// >>> imtb_pkg.sv
// constants and types shared by the interrupt and time-base block
package imtb_pkg;

  // register byte offsets on the AHB-Lite slave
  localparam logic [7:0] PSC0_OFF  = 8'h00;
  localparam logic [7:0] PSC1_OFF  = 8'h04;
  localparam logic [7:0] TIME_BASE0_CONTROL_OFF  = 8'h08;
  localparam logic [7:0] TIME_BASE1_CONTROL_OFF  = 8'h0c;
  localparam logic [7:0] INTC_OFF  = 8'h10;
  localparam logic [7:0] MFSRC_OFF = 8'h14;
  localparam logic [7:0] TBCNT_OFF = 8'h18;

  // prescaler select register fields
  localparam int PSC_SRC_LSB = 0;
  localparam int PSC_SRC_W   = 2;
  localparam logic [1:0] PSC_SRC_RST = 2'h0;
  localparam logic [1:0] PSC_SYS     = 2'h0;
  localparam logic [1:0] PSC_SYS4    = 2'h1;
  localparam int PSC_SUB_BIT = 1;
  localparam logic [1:0] DIV4_LAST   = 2'h3;

  // time-base control register fields
  localparam int TBC_RUN_BIT = 7;
  localparam int TBC_LEN_LSB = 0;
  localparam int TBC_LEN_W   = 3;
  localparam logic       TB_RUN_RST  = 1'b0;
  localparam logic [2:0] TB_LEN_RST  = 3'h0;
  localparam logic [2:0] TB_MAX_CODE = 3'h7;
  localparam int TB_CNT_W = 15;
  localparam logic [14:0] TB_FULL_MASK = 15'h7fff;

  // interrupt control register fields
  localparam int INTC_GIE_BIT    = 0;
  localparam int INTC_ADC_EN_BIT = 1;
  localparam int INTC_TB_EN_LSB  = 2;
  localparam int INTC_SIM_EN_BIT = 4;
  localparam int INTC_MF_EN_LSB  = 5;
  localparam int INTC_ADC_F_BIT  = 8;
  localparam int INTC_TB_F_LSB   = 9;
  localparam int INTC_SIM_F_BIT  = 11;
  localparam int INTC_MF_F_LSB   = 12;

  // shared-channel source register fields
  localparam int MFSRC_F_LSB  = 0;
  localparam int MFSRC_EN_LSB = 8;

  localparam int NUM_MF  = 3;
  localparam int NUM_SRC = 8;
  localparam int NUM_TB  = 2;
  // source bits: 1:0 first timer, 5:2 second and third timer, 7:6 low voltage and eeprom
  localparam logic [2:0][7:0] MF_GROUP = {8'hc0, 8'h3c, 8'h03};

  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic       HRESP_OKAY = 1'b0;

  typedef enum logic [2:0] {
    VEC_MF0 = 3'h0,
    VEC_MF1 = 3'h1,
    VEC_MF2 = 3'h2,
    VEC_ADC = 3'h3,
    VEC_TB0 = 3'h4,
    VEC_TB1 = 3'h5,
    VEC_SIM = 3'h6
  } imtb_vec_type;

endpackage

// >>> imtb_intc.sv
// interrupt request logic with shared channels and two time-base generators
//
// Summary of operation
// - three shared channels merge timer, voltage, eeprom sources
// - any grouped source setting sets channel flag
// - shared vector needs channel, global enable, stack room
// - shared service clears channel flag and global enable
// - service leaves source flags; only software clears them
// - conversion done sets flag; vectors with both enables
// - conversion service clears its flag and global enable
// - time-base overflow sets flag; vectors when enabled
// - time-base service clears its flag and global enable
// - prescaler source: system, system/4, or sub clock
// - control bit 7 runs the time-base, reset off
// - period is two to eight-plus-code prescaler clocks
// - each timer raises match A and match P requests
// - timer vector needs global, own, channel enables
// - serial flag set on byte, address, timeout events
// - serial service clears its flag and global enable
// - unimplemented select and control bits read zero
// - return-from-interrupt sets global enable again
// - any flag rising edge raises wake-up
//
// The implementer's own choices: the register addresses and register access over AHB-Lite.
`timescale 1ns/10ps

module imtb_intc (
  input  wire logic        I_CORE_CLK,
  input  wire logic        I_RST_N,
  input  wire logic        I_CE,
  input  wire logic        I_HSEL,
  input  wire logic [31:0] I_HADDR,
  input  wire logic [1:0]  I_HTRANS,
  input  wire logic        I_HWRITE,
  input  wire logic [2:0]  I_HSIZE,
  input  wire logic [31:0] I_HWDATA,
  input  wire logic        I_HREADY,
  output logic             O_HREADYOUT,
  output logic             O_HRESP,
  output logic [31:0]      O_HRDATA,
  input  wire logic [7:0]  I_TM_EVT,
  input  wire logic        I_ADC_DONE,
  input  wire logic [2:0]  I_SIM_EVT,
  input  wire logic        I_SUB_CLK,
  input  wire logic        I_STACK_FULL,
  input  wire logic        I_IRQ_ACK,
  input  wire logic        I_RETURN_FROM_INTERRUPT_OP,
  output logic             O_IRQ_REQ,
  output logic [2:0]       O_IRQ_VEC,
  output logic             O_GIE,
  output logic             O_WAKE
);

  typedef struct packed {
    logic [1:0][1:0]  psc_src;
    logic [1:0]       tb_run;
    logic [1:0][2:0]  tb_len;
    logic             gie;
    logic             adc_en;
    logic             sim_en;
    logic [1:0]       tb_en;
    logic [2:0]       mf_en;
    logic             adc_f;
    logic             sim_f;
    logic [1:0]       tb_f;
    logic [2:0]       mf_f;
    logic [7:0]       src_f;
    logic [7:0]       src_en;
    logic [1:0][1:0]  div4;
    logic [1:0][14:0] tb_cnt;
    logic             sub_d;
    logic             req;
    imtb_pkg::imtb_vec_type vec;
    logic             wake;
    logic             wr_pend;
    logic [7:0]       waddr;
    logic [31:0]      rdata;
  } imtb_state_type;

  imtb_state_type   st_r;
  imtb_state_type   st_nxt;
  logic             sub_rise;
  logic [1:0]       tick;
  logic [1:0]       wrap;
  logic [1:0][14:0] len_mask;
  logic [31:0]      rd_word;
  logic             addr_ok;
  logic             ack_take;

  assign sub_rise = I_SUB_CLK & ~st_r.sub_d;
  assign addr_ok  = I_HSEL & I_HTRANS[1] & I_HREADY;
  assign ack_take = I_IRQ_ACK & st_r.req;

  // per time-base prescaler tick and wrap detection
  for (genvar g = 0; g < imtb_pkg::NUM_TB; g++) begin : g_tb
    always_comb begin
      if (st_r.psc_src[g][imtb_pkg::PSC_SUB_BIT]) begin
        tick[g] = sub_rise;
      end else if (st_r.psc_src[g] == imtb_pkg::PSC_SYS4) begin
        tick[g] = (st_r.div4[g] == imtb_pkg::DIV4_LAST);
      end else begin
        tick[g] = 1'b1;
      end
    end
    assign len_mask[g] = imtb_pkg::TB_FULL_MASK >> (imtb_pkg::TB_MAX_CODE - st_r.tb_len[g]);
    assign wrap[g] = st_r.tb_run[g] & tick[g] & ((st_r.tb_cnt[g] & len_mask[g]) == len_mask[g]);
  end

  // read data mux, sampled in the address phase
  always_comb begin
    rd_word = 32'h0;
    if (I_HADDR[31:8] == 24'h0) begin
      case (I_HADDR[7:0])
        imtb_pkg::PSC0_OFF: begin
          rd_word[imtb_pkg::PSC_SRC_LSB +: imtb_pkg::PSC_SRC_W] = st_r.psc_src[0];
        end
        imtb_pkg::PSC1_OFF: begin
          rd_word[imtb_pkg::PSC_SRC_LSB +: imtb_pkg::PSC_SRC_W] = st_r.psc_src[1];
        end
        imtb_pkg::TIME_BASE0_CONTROL_OFF: begin
          rd_word[imtb_pkg::TBC_RUN_BIT] = st_r.tb_run[0];
          rd_word[imtb_pkg::TBC_LEN_LSB +: imtb_pkg::TBC_LEN_W] = st_r.tb_len[0];
        end
        imtb_pkg::TIME_BASE1_CONTROL_OFF: begin
          rd_word[imtb_pkg::TBC_RUN_BIT] = st_r.tb_run[1];
          rd_word[imtb_pkg::TBC_LEN_LSB +: imtb_pkg::TBC_LEN_W] = st_r.tb_len[1];
        end
        imtb_pkg::INTC_OFF: begin
          rd_word[imtb_pkg::INTC_GIE_BIT]          = st_r.gie;
          rd_word[imtb_pkg::INTC_ADC_EN_BIT]       = st_r.adc_en;
          rd_word[imtb_pkg::INTC_TB_EN_LSB +: 2]   = st_r.tb_en;
          rd_word[imtb_pkg::INTC_SIM_EN_BIT]       = st_r.sim_en;
          rd_word[imtb_pkg::INTC_MF_EN_LSB +: 3]   = st_r.mf_en;
          rd_word[imtb_pkg::INTC_ADC_F_BIT]        = st_r.adc_f;
          rd_word[imtb_pkg::INTC_TB_F_LSB +: 2]    = st_r.tb_f;
          rd_word[imtb_pkg::INTC_SIM_F_BIT]        = st_r.sim_f;
          rd_word[imtb_pkg::INTC_MF_F_LSB +: 3]    = st_r.mf_f;
        end
        imtb_pkg::MFSRC_OFF: begin
          rd_word[imtb_pkg::MFSRC_F_LSB +: 8]  = st_r.src_f;
          rd_word[imtb_pkg::MFSRC_EN_LSB +: 8] = st_r.src_en;
        end
        imtb_pkg::TBCNT_OFF: begin
          rd_word = {1'b0, st_r.tb_cnt[1], 1'b0, st_r.tb_cnt[0]};
        end
        default: begin
          rd_word = 32'h0;
        end
      endcase
    end
  end

  always_comb begin
    logic [6:0]  pend;
    logic [14:0] flags_old;
    logic [14:0] flags_new;
    pend      = 7'h0;
    flags_old = 15'h0;
    flags_new = 15'h0;
    st_nxt    = st_r;
    st_nxt.sub_d = I_SUB_CLK;

    // bus data phase: write commits when the transfer completes
    if (st_r.wr_pend && I_HREADY) begin
      case (st_r.waddr)
        imtb_pkg::PSC0_OFF: begin
          st_nxt.psc_src[0] = I_HWDATA[imtb_pkg::PSC_SRC_LSB +: imtb_pkg::PSC_SRC_W];
        end
        imtb_pkg::PSC1_OFF: begin
          st_nxt.psc_src[1] = I_HWDATA[imtb_pkg::PSC_SRC_LSB +: imtb_pkg::PSC_SRC_W];
        end
        imtb_pkg::TIME_BASE0_CONTROL_OFF: begin
          st_nxt.tb_run[0] = I_HWDATA[imtb_pkg::TBC_RUN_BIT];
          st_nxt.tb_len[0] = I_HWDATA[imtb_pkg::TBC_LEN_LSB +: imtb_pkg::TBC_LEN_W];
        end
        imtb_pkg::TIME_BASE1_CONTROL_OFF: begin
          st_nxt.tb_run[1] = I_HWDATA[imtb_pkg::TBC_RUN_BIT];
          st_nxt.tb_len[1] = I_HWDATA[imtb_pkg::TBC_LEN_LSB +: imtb_pkg::TBC_LEN_W];
        end
        imtb_pkg::INTC_OFF: begin
          st_nxt.gie    = I_HWDATA[imtb_pkg::INTC_GIE_BIT];
          st_nxt.adc_en = I_HWDATA[imtb_pkg::INTC_ADC_EN_BIT];
          st_nxt.tb_en  = I_HWDATA[imtb_pkg::INTC_TB_EN_LSB +: 2];
          st_nxt.sim_en = I_HWDATA[imtb_pkg::INTC_SIM_EN_BIT];
          st_nxt.mf_en  = I_HWDATA[imtb_pkg::INTC_MF_EN_LSB +: 3];
          st_nxt.adc_f  = I_HWDATA[imtb_pkg::INTC_ADC_F_BIT];
          st_nxt.tb_f   = I_HWDATA[imtb_pkg::INTC_TB_F_LSB +: 2];
          st_nxt.sim_f  = I_HWDATA[imtb_pkg::INTC_SIM_F_BIT];
          st_nxt.mf_f   = I_HWDATA[imtb_pkg::INTC_MF_F_LSB +: 3];
        end
        imtb_pkg::MFSRC_OFF: begin
          st_nxt.src_f  = I_HWDATA[imtb_pkg::MFSRC_F_LSB +: 8];
          st_nxt.src_en = I_HWDATA[imtb_pkg::MFSRC_EN_LSB +: 8];
        end
        default: begin
          st_nxt.src_en = st_r.src_en;
        end
      endcase
    end
    if (I_HREADY) begin
      st_nxt.wr_pend = addr_ok & I_HWRITE & (I_HSIZE == imtb_pkg::HSIZE_WORD);
      st_nxt.waddr   = (I_HADDR[31:8] == 24'h0) ? I_HADDR[7:0] : 8'hff;
    end
    if (addr_ok && !I_HWRITE) begin
      st_nxt.rdata = rd_word;
    end

    if (I_RETURN_FROM_INTERRUPT_OP) begin
      st_nxt.gie = 1'b1;
    end

    // service acknowledge: clear only the served flag, never source flags
    if (ack_take) begin
      st_nxt.gie = 1'b0;
      unique case (st_r.vec)
        imtb_pkg::VEC_MF0: st_nxt.mf_f[0] = 1'b0;
        imtb_pkg::VEC_MF1: st_nxt.mf_f[1] = 1'b0;
        imtb_pkg::VEC_MF2: st_nxt.mf_f[2] = 1'b0;
        imtb_pkg::VEC_ADC: st_nxt.adc_f = 1'b0;
        imtb_pkg::VEC_TB0: st_nxt.tb_f[0] = 1'b0;
        imtb_pkg::VEC_TB1: st_nxt.tb_f[1] = 1'b0;
        imtb_pkg::VEC_SIM: st_nxt.sim_f = 1'b0;
        default: st_nxt.gie = 1'b0;
      endcase
    end

    // hardware events set after every clear so a same-cycle set wins
    st_nxt.src_f = st_nxt.src_f | I_TM_EVT;
    for (int c = 0; c < imtb_pkg::NUM_MF; c++) begin
      if (|(I_TM_EVT & imtb_pkg::MF_GROUP[c])) begin
        st_nxt.mf_f[c] = 1'b1;
      end
    end
    st_nxt.adc_f = st_nxt.adc_f | I_ADC_DONE;
    st_nxt.sim_f = st_nxt.sim_f | (|I_SIM_EVT);
    st_nxt.tb_f  = st_nxt.tb_f | wrap;

    for (int g = 0; g < imtb_pkg::NUM_TB; g++) begin
      st_nxt.div4[g] = st_r.div4[g] + 2'h1;
      if (!st_r.tb_run[g]) begin
        st_nxt.tb_cnt[g] = 15'h0;
      end else if (tick[g]) begin
        st_nxt.tb_cnt[g] = st_r.tb_cnt[g] + 15'h1;
      end
    end

    flags_old = {st_r.src_f, st_r.mf_f, st_r.tb_f, st_r.sim_f, st_r.adc_f};
    flags_new = {st_nxt.src_f, st_nxt.mf_f, st_nxt.tb_f, st_nxt.sim_f, st_nxt.adc_f};
    st_nxt.wake = |(flags_new & ~flags_old);

    // requests evaluated on the state being loaded
    for (int c = 0; c < imtb_pkg::NUM_MF; c++) begin
      pend[c] = st_nxt.mf_f[c] & st_nxt.mf_en[c]
              & (|(st_nxt.src_f & st_nxt.src_en & imtb_pkg::MF_GROUP[c]));
    end
    pend[3] = st_nxt.adc_f & st_nxt.adc_en;
    pend[4] = st_nxt.tb_f[0] & st_nxt.tb_en[0];
    pend[5] = st_nxt.tb_f[1] & st_nxt.tb_en[1];
    pend[6] = st_nxt.sim_f & st_nxt.sim_en;
    st_nxt.req = st_nxt.gie & ~I_STACK_FULL & (|pend);
    st_nxt.vec = imtb_pkg::VEC_SIM;
    for (int p = 5; p >= 0; p--) begin
      if (pend[p]) begin
        st_nxt.vec = imtb_pkg::imtb_vec_type'(p[2:0]);
      end
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      st_r         <= '0;
      st_r.psc_src <= {2{imtb_pkg::PSC_SRC_RST}};
      st_r.tb_run  <= {2{imtb_pkg::TB_RUN_RST}};
      st_r.tb_len  <= {2{imtb_pkg::TB_LEN_RST}};
      st_r.vec     <= imtb_pkg::VEC_MF0;
    end else if (I_CE) begin
      st_r <= st_nxt;
    end
  end

  assign O_HREADYOUT = I_CE;
  assign O_HRESP     = imtb_pkg::HRESP_OKAY;
  assign O_HRDATA    = st_r.rdata;
  assign O_IRQ_REQ   = st_r.req;
  assign O_IRQ_VEC   = st_r.vec;
  assign O_GIE       = st_r.gie;
  assign O_WAKE      = st_r.wake;

  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RST_N);

  mf_flag_set_a: assert property (I_CE && I_TM_EVT[0] |=> st_r.mf_f[0])
    else $error("shared channel 0 flag not set by its source");

  req_needs_en_a: assert property (O_IRQ_REQ && O_IRQ_VEC == 3'h1 |->
      O_GIE && st_r.mf_en[1] && st_r.mf_f[1] && |(st_r.src_f & st_r.src_en & 8'h3c))
    else $error("shared channel 1 requested without all enables");

  mf_svc_clr_a: assert property (I_CE && ack_take && O_IRQ_VEC == 3'h0 && !st_r.wr_pend
      && !(|I_TM_EVT[1:0]) |=> !st_r.mf_f[0] && !O_GIE && !O_IRQ_REQ)
    else $error("shared channel service did not clear flag and enable");

  src_keep_a: assert property (I_CE && ack_take && !st_r.wr_pend |=>
      (st_r.src_f & $past(st_r.src_f)) == $past(st_r.src_f))
    else $error("service cleared a source flag");

  adc_svc_clr_a: assert property (I_CE && ack_take && O_IRQ_VEC == 3'h3 && !st_r.wr_pend
      && !I_ADC_DONE |=> !st_r.adc_f && !O_GIE)
    else $error("conversion service did not clear flag and enable");

  tb_wrap_flag_a: assert property (I_CE && wrap[0] |=> st_r.tb_f[0])
    else $error("time-base 0 wrap did not set flag");

  div4_space_a: assert property ((I_CE && st_r.psc_src[0] == 2'h1 && tick[0]) ##1
      (I_CE && st_r.psc_src[0] == 2'h1) |-> !tick[0] ##1 !tick[0] ##1 !tick[0])
    else $error("divide-by-four prescaler ticks too often");

  len_min_a: assert property (I_CE && st_r.tb_run[0] && st_r.tb_len[0] == 3'h0 &&
      st_r.psc_src[0] == 2'h0 && wrap[0] && !st_r.wr_pend |=> !wrap[0])
    else $error("time-base 0 wrapped on consecutive ticks");

  tb_off_a: assert property (I_CE && !st_r.tb_run[1] && !st_r.wr_pend |=>
      st_r.tb_cnt[1] == 15'h0)
    else $error("stopped time-base 1 counter not held at zero");

  rsvd_zero_a: assert property (I_CE && addr_ok && !I_HWRITE && I_HADDR == 32'h8 |=>
      O_HRDATA[6:3] == 4'h0 && O_HRDATA[31:8] == 24'h0)
    else $error("unimplemented control bits read nonzero");

  return_from_interrupt_op_set_a: assert property (I_CE && I_RETURN_FROM_INTERRUPT_OP && !ack_take && !st_r.wr_pend |=> O_GIE)
    else $error("return from interrupt did not set global enable");

  wake_rise_a: assert property ($rose(st_r.adc_f) || $rose(st_r.sim_f) |-> O_WAKE)
    else $error("flag rise without wake-up");

  prio_a: assert property (O_IRQ_REQ && st_r.adc_f && st_r.adc_en |->
      O_IRQ_VEC <= 3'h3)
    else $error("lower priority request served first");

  adc_flag_set_a: assert property (I_CE && I_ADC_DONE |=> st_r.adc_f)
    else $error("conversion done did not set its flag");

  sim_flag_set_a: assert property (I_CE && (|I_SIM_EVT) |=> st_r.sim_f)
    else $error("serial event did not set its flag");

  tm_src_set_a: assert property (I_CE && I_TM_EVT[3] |=> st_r.src_f[3] && st_r.mf_f[1])
    else $error("timer match did not set source and channel flags");

  adc_req_en_a: assert property (O_IRQ_REQ && O_IRQ_VEC == 3'h3 |->
      O_GIE && st_r.adc_en && st_r.adc_f)
    else $error("conversion requested without its enables");

  tb_req_en_a: assert property (O_IRQ_REQ && O_IRQ_VEC == 3'h5 |->
      O_GIE && st_r.tb_en[1] && st_r.tb_f[1])
    else $error("time-base 1 requested without its enables");

  sim_req_en_a: assert property (O_IRQ_REQ && O_IRQ_VEC == 3'h6 |->
      O_GIE && st_r.sim_en && st_r.sim_f)
    else $error("serial requested without its enables");

  stack_hold_a: assert property (I_CE && I_STACK_FULL |=> !O_IRQ_REQ)
    else $error("request raised while the stack is full");

  tb_svc_clr_a: assert property (I_CE && ack_take && O_IRQ_VEC == 3'h4 && !st_r.wr_pend
      && !wrap[0] |=> !st_r.tb_f[0] && !O_GIE)
    else $error("time-base service did not clear flag and enable");

  sim_svc_clr_a: assert property (I_CE && ack_take && O_IRQ_VEC == 3'h6 && !st_r.wr_pend
      && !(|I_SIM_EVT) |=> !st_r.sim_f && !O_GIE)
    else $error("serial service did not clear flag and enable");

  tb_count_a: assert property (I_CE && st_r.tb_run[0] && tick[0] |=>
      st_r.tb_cnt[0] == $past(st_r.tb_cnt[0]) + 15'h1)
    else $error("running time-base 0 missed a prescaler tick");

  ack_gie_clr_a: assert property (I_CE && ack_take |=> !O_GIE)
    else $error("service left the global enable set");

endmodule

// >>> imtb_core_model.sv
// core sequencer model that takes vectored requests from the block
`timescale 1ns/10ps
module imtb_core_model (
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_take_en,
  input  wire logic [3:0] i_dly,
  input  wire logic       i_req,
  input  wire logic [2:0] i_vec,
  output logic            o_ack,
  output logic [2:0]      o_last_vec,
  output int              o_taken
);
  logic [3:0] wait_r;
  // a request is taken only after it has stood i_dly cycles, to model a busy core
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_ack <= 1'b0;
      o_last_vec <= 3'h0;
      o_taken <= 0;
      wait_r <= 4'h0;
    end else if (o_ack) begin
      o_ack <= 1'b0;
      wait_r <= 4'h0;
    end else if (i_take_en && i_req && wait_r >= i_dly) begin
      o_ack <= 1'b1;
      o_last_vec <= i_vec;
      o_taken <= o_taken + 1;
    end else if (i_req) begin
      wait_r <= wait_r + 4'h1;
    end
  end
endmodule

// >>> mcu_interrupt_and_time_base_tb.sv
// self-checking testbench for the interrupt and time-base block
`timescale 1ns/10ps
module mcu_interrupt_and_time_base_tb;
  logic clk, rst_n, hsel, hwrite, adc, sfull, return_from_interrupt_op, take, ack, req, gie, wake;
  logic hreadyout, hresp, ce;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, sc;
  logic [2:0] hsize, sim, vec, lvec;
  logic [7:0] tm;
  logic [3:0] dly;
  int taken, error_cnt, checked;

  imtb_intc u_imtb_intc (.I_CORE_CLK(clk), .I_RST_N(rst_n), .I_CE(ce), .I_HSEL(hsel),
    .I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(hsize),
    .I_HWDATA(hwdata), .I_HREADY(hreadyout), .O_HREADYOUT(hreadyout), .O_HRESP(hresp),
    .O_HRDATA(hrdata), .I_TM_EVT(tm), .I_ADC_DONE(adc), .I_SIM_EVT(sim), .I_SUB_CLK(sc[1]),
    .I_STACK_FULL(sfull), .I_IRQ_ACK(ack), .I_RETURN_FROM_INTERRUPT_OP(return_from_interrupt_op), .O_IRQ_REQ(req),
    .O_IRQ_VEC(vec), .O_GIE(gie), .O_WAKE(wake));
  imtb_core_model u_imtb_core_model (.i_clk(clk), .i_rst_n(rst_n), .i_take_en(take),
    .i_dly(dly), .i_req(req), .i_vec(vec), .o_ack(ack), .o_last_vec(lvec), .o_taken(taken));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // sub clock with a rising edge every fourth system cycle
  always @(posedge clk) sc <= rst_n ? sc + 2'h1 : 2'h0;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    hsize <= imtb_pkg::HSIZE_WORD;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rchk(input logic [31:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
    chk(32'(hresp), 32'(imtb_pkg::HRESP_OKAY));
  endtask
  task automatic ev(input logic [7:0] t, input logic [2:0] s, input logic a);
    @(posedge clk);
    tm <= t;
    sim <= s;
    adc <= a;
    @(posedge clk);
    tm <= 8'h0;
    sim <= 3'h0;
    adc <= 1'b0;
    #1 chk(32'(wake), 32'h1);
  endtask
  task automatic wtake(input logic [2:0] v);
    int n;
    n = taken;
    for (int i = 0; i < 40 && taken == n; i++) @(posedge clk);
    #1 chk(32'(lvec), 32'(v));
    chk(32'(taken), 32'(n + 1));
  endtask
  task automatic do_return_from_interrupt_op;
    @(posedge clk);
    return_from_interrupt_op <= 1'b1;
    @(posedge clk);
    return_from_interrupt_op <= 1'b0;
    #1 chk(32'(gie), 32'h1);
  endtask

  task automatic t_regs;
    logic [7:0] al[8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h40};
    foreach (al[i]) rchk(32'(al[i]), 32'h0);
    bus(1'b1, 32'(imtb_pkg::PSC0_OFF), 32'hffffffff);
    rchk(32'(imtb_pkg::PSC0_OFF), 32'h3);
    bus(1'b1, 32'(imtb_pkg::TIME_BASE1_CONTROL_OFF), 32'hffffffff);
    rchk(32'(imtb_pkg::TIME_BASE1_CONTROL_OFF), 32'h87);
    bus(1'b1, 32'h40, 32'hffffffff);
    rchk(32'h40, 32'h0);
    bus(1'b1, 32'(imtb_pkg::PSC0_OFF), 32'h0);
    bus(1'b1, 32'(imtb_pkg::TIME_BASE1_CONTROL_OFF), 32'h0);
  endtask
  task automatic t_adc;
    sfull <= 1'b1;
    bus(1'b1, 32'(imtb_pkg::INTC_OFF), 32'h3);
    ev(8'h0, 3'h0, 1'b1);
    repeat (5) @(posedge clk);
    #1 chk(32'(req), 32'h0);
    @(posedge clk);
    sfull <= 1'b0;
    wtake(imtb_pkg::VEC_ADC);
    rchk(32'(imtb_pkg::INTC_OFF), 32'h2);
    do_return_from_interrupt_op;
    bus(1'b1, 32'(imtb_pkg::INTC_OFF), 32'h0);
  endtask
  task automatic t_mf;
    int sb[3] = '{0, 2, 6};
    take <= 1'b0;
    bus(1'b1, 32'(imtb_pkg::MFSRC_OFF), 32'h100);
    bus(1'b1, 32'(imtb_pkg::INTC_OFF), 32'h21);
    ev(8'h02, 3'h0, 1'b0);
    repeat (4) @(posedge clk);
    #1 chk(32'(req), 32'h0);
    rchk(32'(imtb_pkg::INTC_OFF), 32'h1021);
    take <= 1'b1;
    for (int c = 0; c < 3; c++) begin
      bus(1'b1, 32'(imtb_pkg::MFSRC_OFF), 32'(1 << (sb[c] + 8)));
      bus(1'b1, 32'(imtb_pkg::INTC_OFF), 32'(1 | (1 << (5 + c))));
      ev(8'(1 << sb[c]), 3'h0, 1'b0);
      wtake(3'(c));
      rchk(32'(imtb_pkg::INTC_OFF), 32'(1 << (5 + c)));
      rchk(32'(imtb_pkg::MFSRC_OFF), 32'((1 << (sb[c] + 8)) | (1 << sb[c])));
      do_return_from_interrupt_op;
      bus(1'b1, 32'(imtb_pkg::MFSRC_OFF), 32'h0);
    end
    bus(1'b1, 32'(imtb_pkg::INTC_OFF), 32'h0);
  endtask
  task automatic t_sim;
    dly <= 4'h3;
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, 32'(imtb_pkg::INTC_OFF), 32'h11);
      ev(8'h0, 3'(1 << i), 1'b0);
      wtake(imtb_pkg::VEC_SIM);
      rchk(32'(imtb_pkg::INTC_OFF), 32'h10);
      do_return_from_interrupt_op;
    end
    @(posedge clk);
    dly <= 4'h0;
  endtask
  task automatic t_prio;
    sfull <= 1'b1;
    bus(1'b1, 32'(imtb_pkg::INTC_OFF), 32'h13);
    ev(8'h0, 3'h1, 1'b1);
    @(posedge clk);
    sfull <= 1'b0;
    wtake(imtb_pkg::VEC_ADC);
    rchk(32'(imtb_pkg::INTC_OFF), 32'h812);
    do_return_from_interrupt_op;
    wtake(imtb_pkg::VEC_SIM);
    bus(1'b1, 32'(imtb_pkg::INTC_OFF), 32'h0);
  endtask
  // a low clock enable must freeze all state and stretch the bus with wait states
  task automatic t_ce;
    @(posedge clk);
    ce <= 1'b0;
    adc <= 1'b1;
    @(posedge clk);
    adc <= 1'b0;
    fork
      rchk(32'(imtb_pkg::INTC_OFF), 32'h0);
      begin
        repeat (4) @(posedge clk);
        ce <= 1'b1;
      end
    join
  endtask
  task automatic t_tb;
    int tbs[4] = '{0, 0, 1, 1};
    int src[4] = '{0, 1, 0, 2};
    int len[4] = '{0, 0, 1, 0};
    int exp[4] = '{256, 1024, 512, 1024};
    int n, c;
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, 32'(imtb_pkg::PSC0_OFF) + 32'(4 * tbs[k]), 32'(src[k]));
      bus(1'b1, 32'(imtb_pkg::INTC_OFF), 32'(1 | (1 << (2 + tbs[k]))));
      n = taken;
      c = 0;
      bus(1'b1, 32'(imtb_pkg::TIME_BASE0_CONTROL_OFF) + 32'(4 * tbs[k]), 32'(8'h80 | len[k]));
      while (taken == n && c < 40000) begin
        @(posedge clk);
        c++;
      end
      chk(32'(c > exp[k] - 5 && c < exp[k] + 9), 32'h1);
      chk(32'(lvec), 32'(imtb_pkg::VEC_TB0) + 32'(tbs[k]));
      rchk(32'(imtb_pkg::INTC_OFF), 32'(1 << (2 + tbs[k])));
      bus(1'b1, 32'(imtb_pkg::TIME_BASE0_CONTROL_OFF) + 32'(4 * tbs[k]), 32'h0);
      do_return_from_interrupt_op;
      bus(1'b1, 32'(imtb_pkg::INTC_OFF), 32'h0);
    end
  endtask

  task automatic end_sim;
    $display("comparisons=%0d mismatches=%0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge clk);
    error_cnt++;
    end_sim;
  end
  initial begin
    {rst_n, hsel, hwrite, adc, sfull, return_from_interrupt_op, take} = '0;
    {haddr, hwdata, htrans, hsize, sim, tm, dly} = '0;
    ce = 1'b1;
    error_cnt = 0;
    checked = 0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    take <= 1'b1;
    t_regs;
    t_adc;
    t_mf;
    t_sim;
    t_prio;
    t_ce;
    t_tb;
    end_sim;
  end
endmodule
